// [verilog/csc_channel.sv]
// Configurable asynchronous serial channel with AXI4-Lite registers.
// Assumes receive_line_pin is already synchronous to clk_sys and the pad resolves tx enables.
//
// Summary of operation
// - Non-inverted mode idles the transmit line at logic one.
// - Inverted bit 7 complements every frame element; idle becomes zero.
// - Each character starts with a zero start bit lasting one bit time.
// - Every element lasts one bit time, the divider period from the baud.
// - Data bits go out least significant bit first after the start.
// - Parity bit follows the last data bit, before stop bits.
// - One or more stop bits at logic one close each character.
// - Bits 5:4 decode as 11 even, 10 odd, 00 none.
// - Low nibble 5,6,7,8 selects five to eight data bits.
// - Undefined configuration codes are ignored and keep the prior setting.
// - Codes 1011 and 1100 select bussed mode on software channels, driving only the dominant level.
// - Bussed width codes are the normal seven and eight bit codes plus four.
// - Ignore parity in seven-bit mode stores received bytes with MSB zero.
// - Ignore parity in eight-bit mode queues exactly one byte per character.
// - Stored parity in seven-bit mode goes into the byte MSB.
// - Stored parity in eight-bit mode queues a second byte holding parity.
// - Seven-bit characters without parity are stored right-aligned.
// - Inversion is honoured only on software channels 3 through 6.
// - Six-bit width is accepted only on hardware channels.
// - Software channels take 1 to 240 stop bits, else one.
// - Hardware channels use two stop bits when more than one is requested.
// - Receive or transmit may be disabled, but never both.
`timescale 1ns/1ps
module csc_channel
    import csc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        receive_line_pin,
    output logic             transmit_line_pin,
    output logic             transmit_line_oe
);
    // Registers held by software.
    logic [7:0]  cfg;
    logic [7:0]  stop_bit_count;
    logic [15:0] divisor;
    logic [3:0]  channel_no;
    logic        rx_enable;
    logic        tx_enable;
    csc_frame_t  frm;
    logic        sw_chan;
    // Transmit side.
    csc_state_t  tx_state;
    logic [15:0] tx_cnt;
    logic [7:0]  tx_shift;
    logic [3:0]  tx_bits;
    logic [7:0]  tx_stops;
    logic        tx_par;
    logic        tx_level;
    logic        tx_pending;
    logic [7:0]  tx_hold;
    // Receive side.
    csc_state_t  rx_state;
    logic [15:0] rx_cnt;
    logic [7:0]  rx_shift;
    logic [3:0]  rx_bits;
    logic        rx_line;
    logic        rx_prev;
    logic        rx_parbit;
    logic [7:0]  rx_byte;
    logic        rx_full;
    logic        rx_second;
    logic [7:0]  rx_second_byte;
    logic        rx_overrun;
    // Bus handshake state.
    logic        aw_hold;
    logic        w_hold;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic        do_read;
    logic        rx_pop;
    logic [31:0] rd_value;
    logic        rd_ok;
    logic        wr_ok;

    // A software channel is one numbered 3 through 6.
    assign sw_chan = (channel_no >= CSC_SW_FIRST) && (channel_no <= CSC_SW_LAST);
    // Decode the configuration byte into frame settings.
    always_comb begin
        frm.invert     = cfg[CSC_CFG_INV_BIT] & sw_chan;
        frm.ignore_par = cfg[CSC_CFG_IGN_BIT];
        frm.par_en     = cfg[CSC_CFG_PAR_HI];
        frm.par_odd    = (cfg[CSC_CFG_PAR_HI:CSC_CFG_PAR_LO] == CSC_PAR_ODD);
        frm.bussed     = (cfg[3:0] == CSC_W7B) || (cfg[3:0] == CSC_W8B);
        frm.width      = frm.bussed ? (cfg[3:0] - CSC_BUS_OFFSET) : cfg[3:0];
        if (sw_chan) begin
            frm.stops = (stop_bit_count >= 8'h01 && stop_bit_count <= CSC_STOP_MAX) ? stop_bit_count : 8'h01;
        end else begin
            frm.stops = (stop_bit_count > 8'h01) ? 8'h02 : 8'h01;
        end
    end
    // Validity of a written configuration byte; undefined codes are dropped.
    function automatic logic cfg_legal(input logic [7:0] v, input logic sw);
        logic wok;
        logic pok;
        wok = (v[3:0] == CSC_W5) || (v[3:0] == CSC_W7) || (v[3:0] == CSC_W8)
            || (v[3:0] == CSC_W6 && !sw) || ((v[3:0] == CSC_W7B || v[3:0] == CSC_W8B) && sw);
        pok = (v[5:4] != 2'h1);
        return wok && pok;
    endfunction
    // Write channel handshake: address and data are taken in either order.
    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold && !s_axi_bvalid;
    assign do_write      = aw_hold && w_hold && !s_axi_bvalid;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_hold <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_hold <= 1'b0;
            end
        end
    end
    // Write decode and response.
    assign wr_ok = (aw_addr == CSC_OFF_CFG) || (aw_addr == CSC_OFF_STOP) || (aw_addr == CSC_OFF_DIV)
                || (aw_addr == CSC_OFF_TXDATA) || (aw_addr == CSC_OFF_CHAN);
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s_axi_bvalid   <= 1'b0;
            s_axi_bresp    <= CSC_RESP_OKAY;
            cfg            <= CSC_CFG_RESET;
            stop_bit_count <= CSC_STOP_RESET;
            divisor        <= CSC_DIV_RESET;
            channel_no     <= CSC_CHAN_RESET;
            rx_enable      <= 1'b1;
            tx_enable      <= 1'b1;
        end else begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? CSC_RESP_OKAY : CSC_RESP_SLVERR;
                if (aw_addr == CSC_OFF_CFG && w_strb[0] && cfg_legal(w_data[7:0], sw_chan)) begin
                    cfg <= w_data[7:0];
                end
                if (aw_addr == CSC_OFF_STOP && w_strb[0]) begin
                    stop_bit_count <= w_data[7:0];
                end
                if (aw_addr == CSC_OFF_DIV) begin
                    if (w_strb[0]) divisor[7:0] <= w_data[7:0];
                    if (w_strb[1]) divisor[15:8] <= w_data[15:8];
                end
                if (aw_addr == CSC_OFF_CHAN && w_strb[0] && (w_data[5] || w_data[4])) begin
                    channel_no <= w_data[3:0];
                    rx_enable  <= w_data[4];
                    tx_enable  <= w_data[5];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // Read decode: status shows transmitter busy, receive data and overrun.
    assign s_axi_arready = !s_axi_rvalid;
    assign do_read = s_axi_arvalid && s_axi_arready;
    assign rx_pop  = do_read && (s_axi_araddr == CSC_OFF_RXDATA) && rx_full;
    always_comb begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            CSC_OFF_CFG:    rd_value = {24'h0, cfg};
            CSC_OFF_STOP:   rd_value = {24'h0, stop_bit_count};
            CSC_OFF_DIV:    rd_value = {16'h0, divisor};
            CSC_OFF_TXDATA: rd_value = {24'h0, tx_hold};
            CSC_OFF_RXDATA: rd_value = {23'h0, rx_full, rx_byte};
            CSC_OFF_STATUS: rd_value = {28'h0, rx_overrun, rx_full, tx_pending, tx_state != CSC_IDLE};
            CSC_OFF_CHAN:   rd_value = {26'h0, tx_enable, rx_enable, channel_no};
            default: begin
                rd_value = 32'h0000_0000;
                rd_ok    = 1'b0;
            end
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= CSC_RESP_OKAY;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_value;
            s_axi_rresp  <= rd_ok ? CSC_RESP_OKAY : CSC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    // Transmit holding register; a write while full is dropped.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            tx_pending <= 1'b0;
            tx_hold    <= 8'h00;
        end else if (do_write && aw_addr == CSC_OFF_TXDATA && w_strb[0] && !tx_pending && tx_enable) begin
            tx_pending <= 1'b1;
            tx_hold    <= w_data[7:0];
        end else if (tx_state == CSC_IDLE && tx_pending) begin
            tx_pending <= 1'b0;
        end
    end
    // Transmit frame sequencer; each element lasts divisor clocks.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            tx_state <= CSC_IDLE;
            tx_cnt   <= 16'h0000;
            tx_shift <= 8'h00;
            tx_bits  <= 4'h0;
            tx_stops <= 8'h00;
            tx_par   <= 1'b0;
            tx_level <= 1'b1;
        end else begin
            case (tx_state)
                CSC_IDLE: begin
                    tx_level <= 1'b1;
                    if (tx_pending) begin
                        tx_state <= CSC_START;
                        tx_shift <= tx_hold;
                        tx_bits  <= frm.width;
                        tx_par   <= frm.par_odd;
                        tx_stops <= frm.stops;
                        tx_cnt   <= divisor - 16'h0001;
                        tx_level <= 1'b0;
                    end
                end
                CSC_START, CSC_DATA, CSC_PAR, CSC_STOPS: begin
                    if (tx_cnt != 16'h0000) begin
                        tx_cnt <= tx_cnt - 16'h0001;
                    end else begin
                        tx_cnt <= divisor - 16'h0001;
                        if (tx_state != CSC_STOPS && tx_bits != 4'h0) begin
                            tx_state <= CSC_DATA;
                            tx_level <= tx_shift[0];
                            tx_par   <= tx_par ^ tx_shift[0];
                            tx_shift <= {1'b0, tx_shift[7:1]};
                            tx_bits  <= tx_bits - 4'h1;
                        end else if (tx_state == CSC_DATA && frm.par_en) begin
                            tx_state <= CSC_PAR;
                            tx_level <= tx_par;
                        end else if (tx_state != CSC_STOPS || tx_stops > 8'h01) begin
                            if (tx_state == CSC_STOPS) tx_stops <= tx_stops - 8'h01;
                            tx_state <= CSC_STOPS;
                            tx_level <= 1'b1;
                        end else begin
                            tx_state <= CSC_IDLE;
                            tx_level <= 1'b1;
                        end
                    end
                end
                default: tx_state <= CSC_IDLE;
            endcase
        end
    end
    // Pin drive: polarity applied, bussed mode drives only the dominant zero.
    assign transmit_line_pin = tx_level ^ frm.invert;
    assign transmit_line_oe  = tx_enable && (!frm.bussed || !tx_level);
    // Receiver: start edge detection, mid-bit sampling and byte assembly.
    assign rx_line = receive_line_pin ^ frm.invert;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rx_state  <= CSC_IDLE;
            rx_cnt    <= 16'h0000;
            rx_shift  <= 8'h00;
            rx_bits   <= 4'h0;
            rx_prev   <= 1'b1;
            rx_parbit <= 1'b0;
        end else begin
            rx_prev <= rx_line;
            case (rx_state)
                CSC_IDLE: begin
                    if (rx_enable && rx_prev && !rx_line) begin
                        rx_state <= CSC_START;
                        rx_cnt   <= {1'b0, divisor[15:1]};
                        rx_bits  <= frm.width;
                        rx_shift <= 8'h00;
                    end
                end
                CSC_START, CSC_DATA, CSC_PAR: begin
                    if (rx_cnt != 16'h0000) begin
                        rx_cnt <= rx_cnt - 16'h0001;
                    end else begin
                        rx_cnt <= divisor - 16'h0001;
                        if (rx_state == CSC_START && rx_line) begin
                            rx_state <= CSC_IDLE;
                        end else if (rx_state == CSC_START) begin
                            rx_state <= CSC_DATA;
                        end else if (rx_state == CSC_DATA && rx_bits != 4'h0) begin
                            rx_shift <= {rx_line, rx_shift[7:1]};
                            rx_bits  <= rx_bits - 4'h1;
                            if (rx_bits == 4'h1 && !frm.par_en) rx_state <= CSC_STOPS;
                            if (rx_bits == 4'h1 && frm.par_en) rx_state <= CSC_PAR;
                        end else begin
                            rx_parbit <= rx_line;
                            rx_state  <= CSC_STOPS;
                        end
                    end
                end
                CSC_STOPS: begin
                    rx_state <= CSC_IDLE;
                end
                default: rx_state <= CSC_IDLE;
            endcase
        end
    end
    // Receive store: right-align the character and place parity per mode.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rx_byte        <= 8'h00;
            rx_full        <= 1'b0;
            rx_second      <= 1'b0;
            rx_second_byte <= 8'h00;
            rx_overrun     <= 1'b0;
        end else begin
            if (rx_state == CSC_STOPS) begin
                rx_overrun <= rx_full;
                rx_full    <= 1'b1;
                rx_byte    <= rx_shift >> (4'h8 - frm.width);
                if (frm.width == CSC_W7 && frm.par_en) begin
                    rx_byte[7] <= frm.ignore_par ? 1'b0 : rx_parbit;
                end
                rx_second      <= frm.width == CSC_W8 && frm.par_en && !frm.ignore_par;
                rx_second_byte <= {7'h00, rx_parbit};
            end else if (rx_pop && rx_second) begin
                rx_byte   <= rx_second_byte;
                rx_second <= 1'b0;
            end else if (rx_pop) begin
                rx_full <= 1'b0;
            end
        end
    end

    // Assertions on pin behaviour and frame decoding.
    a_idle_line_high: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (tx_state == CSC_IDLE && !frm.invert) |-> transmit_line_pin)
        else $error("Transmit line not idle high.");
    a_invert_idle_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (tx_state == CSC_IDLE && frm.invert) |-> !transmit_line_pin)
        else $error("Inverted idle level wrong.");
    a_start_bit_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (tx_state == CSC_START) |-> !tx_level)
        else $error("Start bit not zero.");
    a_start_enters: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (tx_state == CSC_IDLE && tx_pending) |=> (tx_state == CSC_START && tx_cnt == $past(divisor) - 16'h0001))
        else $error("Start bit length wrong.");
    a_par_after_data: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (tx_state == CSC_PAR) |-> frm.par_en && tx_bits == 4'h0)
        else $error("Parity out of place.");
    a_stop_level_one: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (tx_state == CSC_STOPS) |-> tx_level)
        else $error("Stop bit not one.");
    a_bussed_release: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (frm.bussed && tx_level) |-> !transmit_line_oe)
        else $error("Bussed line driven at recessive level.");
    a_hw_no_invert: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !sw_chan |-> !frm.invert)
        else $error("Hardware channel inverted.");
    a_stop_range: assert property (@(posedge clk_sys) disable iff (!reset_n)
        frm.stops >= 8'h01 && frm.stops <= CSC_STOP_MAX && (sw_chan || frm.stops <= 8'h02))
        else $error("Stop count out of range.");
    a_one_pin_on: assert property (@(posedge clk_sys) disable iff (!reset_n)
        rx_enable || tx_enable)
        else $error("Both pins unassigned.");
    a_seven_msb_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ($past(rx_state) == CSC_STOPS && frm.width == CSC_W7 && frm.ignore_par) |-> !rx_byte[7])
        else $error("Seven-bit MSB not cleared.");
endmodule

// [include/csc_pkg.sv]
// Package for the configurable serial channel: register map, fields and timing.
// Assumes a 20 MHz system clock and an AXI4-Lite register bus with 32-bit data.
package csc_pkg;
    // Register byte offsets.
    localparam logic [7:0] CSC_OFF_CFG    = 8'h00;
    localparam logic [7:0] CSC_OFF_STOP   = 8'h04;
    localparam logic [7:0] CSC_OFF_DIV    = 8'h08;
    localparam logic [7:0] CSC_OFF_TXDATA = 8'h0c;
    localparam logic [7:0] CSC_OFF_RXDATA = 8'h10;
    localparam logic [7:0] CSC_OFF_STATUS = 8'h14;
    localparam logic [7:0] CSC_OFF_CHAN   = 8'h18;
    // Configuration byte fields.
    localparam int CSC_CFG_INV_BIT    = 7;
    localparam int CSC_CFG_IGN_BIT    = 6;
    localparam int CSC_CFG_PAR_HI     = 5;
    localparam int CSC_CFG_PAR_LO     = 4;
    localparam int CSC_CFG_BUS_BIT    = 2;
    localparam logic [1:0] CSC_PAR_EVEN = 2'h3;
    localparam logic [1:0] CSC_PAR_ODD  = 2'h2;
    localparam logic [1:0] CSC_PAR_NONE = 2'h0;
    localparam logic [3:0] CSC_W5   = 4'h5;
    localparam logic [3:0] CSC_W6   = 4'h6;
    localparam logic [3:0] CSC_W7   = 4'h7;
    localparam logic [3:0] CSC_W8   = 4'h8;
    localparam logic [3:0] CSC_W7B  = 4'hb;
    localparam logic [3:0] CSC_W8B  = 4'hc;
    localparam logic [3:0] CSC_BUS_OFFSET = 4'h4;
    // Reset values, stop bit limit and software channel range.
    localparam logic [7:0]  CSC_CFG_RESET  = 8'h08;
    localparam logic [7:0]  CSC_STOP_RESET = 8'h01;
    localparam logic [7:0]  CSC_STOP_MAX   = 8'hf0;
    localparam logic [3:0]  CSC_CHAN_RESET = 4'h3;
    localparam logic [3:0]  CSC_SW_FIRST   = 4'h3;
    localparam logic [3:0]  CSC_SW_LAST    = 4'h6;
    // Timing: system clock and default baud rate.
    localparam int CSC_CLK_HZ       = 20000000;
    localparam int CSC_BAUD_DEFAULT = 9600;
    localparam logic [15:0] CSC_DIV_RESET = 16'(CSC_CLK_HZ / CSC_BAUD_DEFAULT);
    // AXI responses.
    localparam logic [1:0] CSC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CSC_RESP_SLVERR = 2'h2;
    // Decoded frame settings.
    typedef struct packed {
        logic       invert;
        logic       ignore_par;
        logic       par_en;
        logic       par_odd;
        logic       bussed;
        logic [3:0] width;
        logic [7:0] stops;
    } csc_frame_t;
    typedef enum logic [2:0] {CSC_IDLE, CSC_START, CSC_DATA, CSC_PAR, CSC_STOPS} csc_state_t;
endpackage

// [verif/csc_remote.sv]
// Model of the remote serial device that drives the channel's receive line.
// Assumes the bench gives the frame bits, their count and the bit time in clocks.
`timescale 1ns/1ps
module csc_remote (
    input  wire logic        clk_sys,
    input  wire logic        go,
    input  wire logic        inv,
    input  wire logic [8:0]  bits,
    input  wire logic [3:0]  nel,
    input  wire logic [15:0] div,
    output logic             line,
    output logic             busy
);
    logic lvl = 1'b1;
    int   j;
    // The line carries the logical level, complemented in inverted mode.
    assign line = lvl ^ inv;
    initial busy = 1'b0;
    // One frame: start bit, nel bits least significant first, one stop bit.
    always @(posedge clk_sys) begin
        if (go && !busy) begin
            busy <= 1'b1;
            for (j = 0; j < nel + 2; j++) begin
                lvl <= (j == 0) ? 1'b0 : (j > nel) ? 1'b1 : bits[j-1];
                repeat (div) @(posedge clk_sys);
            end
            busy <= 1'b0;
        end
    end
endmodule

// [verif/configurable_serial_channel_bench.sv]
// Self-checking bench for the serial channel: register bus, transmit frames, receive queue.
// Assumes a 16-clock bit time set through the divider register.
`timescale 1ns/1ps
module configurable_serial_channel_bench import csc_pkg::*; ();
    logic        clk_sys = 1'b0, reset_n = 1'b0, go = 1'b0, inv = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, rd_v;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [8:0]  rbits = 9'h0;
    logic [3:0]  nel = 4'h0;
    logic [1:0]  rsp;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire         receive_line_pin, transmit_line_pin, transmit_line_oe, r_busy;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire [31:0]  s_axi_rdata;
    int          n_fail = 0, samples_checked = 0, seed = 32'h9750;
    logic [8:0]  rxq[$];
    logic [7:0]  cfgs[9] = '{8'h08, 8'h37, 8'h77, 8'h28, 8'h68, 8'h05, 8'h88, 8'h0b, 8'h0c};
    // A released pin is pulled to the idle level.
    wire tx_lvl = transmit_line_oe ? transmit_line_pin : !inv;
    always #25 clk_sys = ~clk_sys;
    csc_channel dut_u (.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .receive_line_pin, .transmit_line_pin, .transmit_line_oe);
    csc_remote rem_u (.clk_sys, .go, .inv, .bits(rbits), .nel, .div(16'h0010), .line(receive_line_pin),
        .busy(r_busy));
    // Compares one result and counts it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic tmo;
        n_fail++;
        $display("[ERR] %0t wait ran out", $time);
        stop_test;
    endtask
    // Write: address and data offered together, each released once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        logic ta, tw, tb;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 99; i++) begin
            @(negedge clk_sys);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge clk_sys);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) break;
        end
        if (i == 99) tmo;
    endtask
    // Read: data and response are taken at the edge where rvalid is seen.
    task automatic rd(input logic [7:0] a);
        int i;
        logic ta, tr;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 99; i++) begin
            @(negedge clk_sys);
            ta = s_axi_arready;
            tr = s_axi_rvalid;
            rd_v = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge clk_sys);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) break;
        end
        if (i == 99) tmo;
    endtask
    // Reset, register checks, then one transmit and one receive frame per format.
    initial begin
        int k, e, w;
        logic [7:0] c, t, d;
        logic p, b, bus;
        logic [8:0] x;
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rd(CSC_OFF_CFG);
        chk(rd_v[7:0], CSC_CFG_RESET);
        rd(8'h1c);
        chk(rsp, CSC_RESP_SLVERR);
        chk(rd_v, 32'h0);
        wr(8'h1c, 32'h0);
        chk(rsp, CSC_RESP_SLVERR);
        wr(CSC_OFF_DIV, 32'h10);
        chk(rsp, CSC_RESP_OKAY);
        wr(CSC_OFF_STOP, 32'h02);
        for (k = 0; k < 9; k++) begin
            c = cfgs[k];
            bus = (c[3:0] == CSC_W7B) || (c[3:0] == CSC_W8B);
            w = int'(c[3:0]) - (bus ? 4 : 0);
            wr(CSC_OFF_CFG, c);
            inv <= c[7];
            rd(CSC_OFF_CFG);
            chk(rd_v[7:0], c);
            chk(tx_lvl, !inv);
            t = 8'($random(seed));
            d = t & 8'((1 << w) - 1);
            p = ^d ^ !c[4];
            wr(CSC_OFF_TXDATA, t);
            for (e = 0; e < 99 && tx_lvl === !inv; e++) @(negedge clk_sys);
            if (e == 99) tmo;
            repeat (8) @(negedge clk_sys);
            chk({transmit_line_oe, tx_lvl}, {1'b1, inv});
            for (e = 0; e < w + c[5] + 2; e++) begin
                repeat (16) @(negedge clk_sys);
                b = (e < w) ? t[e] : (e == w && c[5]) ? p : 1'b1;
                chk({transmit_line_oe, tx_lvl}, {!bus || !b, b ^ inv});
            end
            // Mid second stop bit the transmitter must still be busy.
            @(posedge clk_sys);
            rd(CSC_OFF_STATUS);
            chk(rd_v[0], 1'b1);
            rbits <= c[5] ? (9'(d) | (9'(p) << w)) : 9'(d);
            nel <= 4'(w + c[5]);
            go <= 1'b1;
            @(posedge clk_sys);
            go <= 1'b0;
            for (e = 0; e < 999; e++) begin
                @(posedge clk_sys);
                if (!r_busy) break;
            end
            if (e == 999) tmo;
            rxq.push_back({1'b1, (w == 7 && c[5] && !c[6]) ? {p, d[6:0]} : d});
            if (w == 8 && c[5] && !c[6]) rxq.push_back({8'h80, p});
            rxq.push_back(9'h0);
            while (rxq.size() > 0) begin
                x = rxq.pop_front();
                rd(CSC_OFF_RXDATA);
                chk(x[8] ? rd_v[8:0] : 9'(rd_v[8]), x);
            end
        end
        wr(CSC_OFF_CFG, 32'h06);
        rd(CSC_OFF_CFG);
        chk(rd_v[7:0], 8'h0c);
        wr(CSC_OFF_CHAN, 32'h03);
        rd(CSC_OFF_CHAN);
        chk(rd_v[5:0], 6'h33);
        stop_test;
    end
endmodule
